// >>> testbench/drc_param_regs_assertions.sv
// Purpose: Port-level checks on the controller register file
// Assumes: checks pause while ce is low; one write and one read at a time
// Notes: Bus latencies are the ones the register file promises
`timescale 1ns/100ps
module drc_param_regs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic path1_gate_enable,
   input wire logic path1_gate_in_active,
   input wire logic path2_quick_release_enable,
   input wire logic path2_anti_clip_enable,
   input wire logic [3:0] path2_attack_rate,
   input wire logic [3:0] path2_decay_rate,
   input wire logic [2:0] path2_min_gain,
   input wire logic signed [6:0] path2_min_gain_db
);
   logic signed [6:0] db_exp;
   // Reserved codes must decode to 0 dB, not to a stale value
   always_comb begin
      case (path2_min_gain)
         3'h1: db_exp = 7'h74;
         3'h2: db_exp = 7'h6e;
         3'h3: db_exp = 7'h68;
         3'h4: db_exp = 7'h5c;
         default: db_exp = 7'h00;
      endcase
   end
   default clocking cb @(posedge aclk); endclocking
   // Frozen cycles take no handshake, so latency checks stand aside
   default disable iff (!aresetn || !ce);
   rst_enables_a: assert property (
      $rose(aresetn) |-> path2_quick_release_enable && path2_anti_clip_enable)
      else $error("quick release or anti-clip not enabled after reset");
   rst_rates_a: assert property (
      $rose(aresetn) |-> path2_attack_rate == 4'h4 && path2_decay_rate == 4'h2
         && path2_min_gain == 3'h1 && path2_min_gain_db == 7'h74)
      else $error("rate or gain reset value wrong");
   gate_active_a: assert property (
      $past(aresetn) |-> path1_gate_in_active == $past(path1_gate_enable))
      else $error("gate active does not follow gate enable");
   min_gain_db_a: assert property (
      $past(aresetn) |-> path2_min_gain_db == $past(db_exp))
      else $error("minimum gain decode wrong");
   rate_write_a: assert property (
      $changed(path2_attack_rate) |-> s_axi_bvalid)
      else $error("attack rate changed without a write");
   wr_resp_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after request");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after request");
   rvalid_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule

bind drc_param_regs drc_param_regs_checker drc_param_regs_checker_i (
   .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .path1_gate_enable, .path1_gate_in_active, .path2_quick_release_enable,
   .path2_anti_clip_enable, .path2_attack_rate, .path2_decay_rate, .path2_min_gain,
   .path2_min_gain_db);

// >>> testbench/drc_param_regs_tb.sv
// Purpose: Self-checking bench for the controller parameter registers
// Assumes: ce high except in the freeze test, one transfer at a time
// Notes: Only defined codes are written; unmapped bits are set to prove they drop
`timescale 1ns/100ps
module drc_param_regs_tb;
   import drc_regs_pkg::*;
   logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [2:0] path1_lower_slope, path2_min_gain;
   logic [5:0] path1_knee_in_level;
   logic [4:0] path1_knee_out_level, path1_gate_knee_in_level, path1_gate_knee_out_level;
   logic path1_gate_enable, path1_gate_knee_out_enable, path1_gate_in_active;
   logic path1_gate_out_active, path2_gate_enable, path2_gate_knee_out_enable;
   logic path2_quick_release_enable, path2_anti_clip_enable;
   logic [3:0] path2_attack_rate, path2_decay_rate;
   logic signed [6:0] path2_min_gain_db;
   int fails, cmp_count;

   drc_param_regs drc_param_regs_i (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .path1_lower_slope, .path1_knee_in_level, .path1_knee_out_level,
      .path1_gate_knee_in_level, .path1_gate_knee_out_level, .path1_gate_enable,
      .path1_gate_knee_out_enable, .path1_gate_in_active, .path1_gate_out_active,
      .path2_gate_enable, .path2_gate_knee_out_enable, .path2_quick_release_enable,
      .path2_anti_clip_enable, .path2_attack_rate, .path2_decay_rate, .path2_min_gain,
      .path2_min_gain_db);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Leading edge keeps bready/rready from being driven twice in one step
   task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
      s_axi_bready <= 1'b0;
   endtask

   // Slow reads hold rready low until data is offered
   task automatic rd(input logic [11:0] idx, input logic slow, input logic [31:0] exp,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      repeat (50) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      chk(s_axi_rdata, exp);
      chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
      s_axi_rready <= 1'b0;
   endtask

   task automatic t_reset;
      rd(IDX_P2_ENABLES, 1'b0, 32'h18, RESP_OKAY);
      rd(IDX_P2_RATES, 1'b0, 32'h844, RESP_OKAY);
      rd(IDX_P1_KNEE, 1'b0, 32'h0, RESP_OKAY);
      rd(IDX_P1_GATE, 1'b0, 32'h0, RESP_OKAY);
      chk({25'h0, path2_min_gain_db}, 32'h74);
      $display("reset values done");
   endtask

   task automatic t_levels;
      wr(IDX_P1_KNEE, 16'hf821, RESP_OKAY);
      rd(IDX_P1_KNEE, 1'b0, 32'h021, RESP_OKAY);
      wr(IDX_P1_KNEE, 16'h079e, RESP_OKAY);
      chk({21'h0, path1_knee_in_level, path1_knee_out_level}, 32'h79e);
      wr(IDX_P1_GATE, 16'hffe0, RESP_OKAY);
      rd(IDX_P1_GATE, 1'b0, 32'h3e0, RESP_OKAY);
      chk({22'h0, path1_gate_knee_in_level, path1_gate_knee_out_level}, 32'h3e0);
      wr(IDX_P1_ENABLES, 16'hffff, RESP_OKAY);
      rd(IDX_P1_ENABLES, 1'b0, 32'h120, RESP_OKAY);
      chk({28'h0, path1_gate_enable, path1_gate_knee_out_enable,
         path1_gate_in_active, path1_gate_out_active}, 32'hf);
      $display("knee levels done");
   endtask

   task automatic t_slope;
      // Reserved slope codes stay unwritten
      for (int c = 0; c < 5; c++) begin
         wr(IDX_P1_SLOPE, 16'(c), RESP_OKAY);
         rd(IDX_P1_SLOPE, 1'b0, 32'(c), RESP_OKAY);
         chk({29'h0, path1_lower_slope}, 32'(c));
      end
      $display("slope codes done");
   endtask

   task automatic t_enables;
      logic [15:0] v;
      for (int i = 0; i < 2; i++) begin
         v = i ? 16'h0000 : 16'hffff;
         wr(IDX_P2_ENABLES, v, RESP_OKAY);
         rd(IDX_P2_ENABLES, 1'b0, {16'h0, v & 16'h0138}, RESP_OKAY);
         chk({28'h0, path2_gate_enable, path2_gate_knee_out_enable,
            path2_quick_release_enable, path2_anti_clip_enable}, {28'h0, v[3:0]});
      end
      $display("path two enables done");
   endtask

   task automatic t_rates;
      logic [6:0] db [5] = '{7'h00, 7'h74, 7'h6e, 7'h68, 7'h5c};
      for (int c = 0; c < 5; c++) begin
         wr(IDX_P2_RATES, {3'h0, 4'hb, 4'h8, 3'(c), 2'h0}, RESP_OKAY);
         rd(IDX_P2_RATES, 1'b1, {19'h0, 4'hb, 4'h8, 3'(c), 2'h0}, RESP_OKAY);
         chk({21'h0, path2_attack_rate, path2_decay_rate, path2_min_gain},
            {21'h0, 4'hb, 4'h8, 3'(c)});
         chk({25'h0, path2_min_gain_db}, {25'h0, db[c]});
      end
      $display("rates and gain done");
   endtask

   task automatic t_refused;
      wr(12'h001, 16'hffff, RESP_SLVERR);
      wr(IDX_STATUS, 16'h0000, RESP_SLVERR);
      rd(12'h000, 1'b1, 32'h0, RESP_SLVERR);
      rd(IDX_P1_SLOPE, 1'b0, 32'h4, RESP_OKAY);
      rd(IDX_STATUS, 1'b0, 32'h0, RESP_OKAY);
      $display("refused accesses done");
   endtask

   // Frozen bus must leave a standing request untaken; upper lane only once it runs
   task automatic t_freeze;
      @(posedge aclk);
      ce <= 1'b0;
      s_axi_awaddr <= {IDX_P2_RATES, 2'b00};
      s_axi_wdata <= 32'h0000_0644;
      s_axi_wstrb <= 4'h2;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      repeat (4) @(posedge aclk);
      chk({24'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, 1'b0,
         path2_attack_rate}, {24'h0, 4'hc, 4'hb});
      ce <= 1'b1;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      repeat (2) @(posedge aclk);
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, RESP_OKAY});
      s_axi_bready <= 1'b0;
      s_axi_wstrb <= 4'hf;
      rd(IDX_P2_RATES, 1'b0, 32'h610, RESP_OKAY);
      $display("clock enable freeze done");
   endtask

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      ce = 1'b1;
      fails = 0;
      cmp_count = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_levels();
      t_slope();
      t_enables();
      t_rates();
      t_refused();
      t_freeze();
      give_verdict();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      give_verdict();
   end
endmodule

// >>> verilog/drc_param_check.sv
// Purpose: Registered decode of stored controller codes
// Assumes: Same clock, reset and clock enable as the register file
// Notes: Reserved codes are flagged, never altered
`timescale 1ns/100ps
module drc_param_check
   import drc_regs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [2:0] slope,
   input wire logic [5:0] knee_in,
   input wire logic [4:0] knee_out,
   input wire logic gate_ena,
   input wire logic gate_out_ena,
   input wire logic [3:0] attack,
   input wire logic [3:0] decay,
   input wire logic [2:0] min_gain,
   output logic gate_in_active,
   output logic gate_out_active,
   output logic signed [6:0] min_gain_db,
   output logic [5:0] reserved_flags
);
   function automatic logic signed [6:0] gain_db(input logic [2:0] code);
      case (code)
         3'h0: gain_db = 7'sd0;
         3'h1: gain_db = -7'sd12;
         3'h2: gain_db = -7'sd18;
         3'h3: gain_db = -7'sd24;
         3'h4: gain_db = -7'sd36;
         default: gain_db = 7'sd0;
      endcase
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_in_active <= 1'b0;
         gate_out_active <= 1'b0;
      end else if (ce) begin
         gate_in_active <= gate_ena;
         gate_out_active <= gate_out_ena;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         min_gain_db <= -7'sd12;
      end else if (ce) begin
         min_gain_db <= gain_db(min_gain);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reserved_flags <= 6'h00;
      end else if (ce) begin
         reserved_flags[0] <= slope > SLOPE_MAX;
         reserved_flags[1] <= knee_in > KNEE_IN_MAX;
         reserved_flags[2] <= knee_out > KNEE_OUT_MAX;
         reserved_flags[3] <= (attack < ATTACK_MIN) || (attack > ATTACK_MAX);
         reserved_flags[4] <= decay > DECAY_MAX;
         reserved_flags[5] <= min_gain > MIN_GAIN_MAX;
      end
   end
endmodule

// >>> verilog/drc_param_regs.sv
// Purpose: AXI4-Lite register file for dynamic range controller parameters
// Assumes: One write and one read outstanding at most, 16-bit fields in low half
// Notes: Outputs feed the gain engine directly from the stored fields, except the registered gate active flags and path2_min_gain_db
`timescale 1ns/100ps

// Overview of operation
// - Path one lower compressor slope is three bits; codes above 100 reserved.
// - Knee input level, bits 10:5, 0.75 dB steps down to -45 dB.
// - Knee output level, bits 4:0, 0.75 dB steps down to -22.5 dB.
// - Gate knee input, bits 9:5, -36 to -82.5 dB, only with gate enabled.
// - Gate knee output, bits 4:0, -30 to -76.5 dB, needs its output enable.
// - Path two gate enable bit 8, knee output enable bit 5, reset off.
// - Path two quick-release enable at bit 4, resets enabled.
// - Path two anti-clip enable at bit 3, resets enabled.
// - Attack rate bits 12:9, reset 0100; codes 0000 and 1100 up reserved.
// - Decay rate bits 8:5, reset 0010; codes 1001 up reserved.
// - Minimum gain bits 4:2, reset 001 meaning -12 dB.
module drc_param_regs
   import drc_regs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [drc_regs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [drc_regs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [2:0] path1_lower_slope,
   output logic [5:0] path1_knee_in_level,
   output logic [4:0] path1_knee_out_level,
   output logic [4:0] path1_gate_knee_in_level,
   output logic [4:0] path1_gate_knee_out_level,
   output logic path1_gate_enable,
   output logic path1_gate_knee_out_enable,
   output logic path1_gate_in_active,
   output logic path1_gate_out_active,
   output logic path2_gate_enable,
   output logic path2_gate_knee_out_enable,
   output logic path2_quick_release_enable,
   output logic path2_anti_clip_enable,
   output logic [3:0] path2_attack_rate,
   output logic [3:0] path2_decay_rate,
   output logic [2:0] path2_min_gain,
   output logic signed [6:0] path2_min_gain_db
);
   import drc_regs_pkg::*;

   logic [15:0] p1_enables_r;
   logic [15:0] p1_slope_r;
   logic [15:0] p1_knee_r;
   logic [15:0] p1_gate_r;
   logic [15:0] p2_enables_r;
   logic [15:0] p2_rates_r;
   logic [5:0] reserved_flags;
   logic [5:0] reserved_seen_r;
   logic [5:0] reserved_seen_nxt;

   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic aw_held_r;
   logic w_held_r;
   logic [11:0] wr_idx_r;
   logic [15:0] wr_data_r;
   logic [1:0] wr_strb_r;

   logic aw_take;
   logic w_take;
   logic do_write;
   logic ar_take;
   logic [11:0] rd_idx;
   logic rd_hit;
   logic [15:0] rd_word;
   logic wr_hit;

   // Byte lane merge; only mapped field bits ever change
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                         input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] lane;
      lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old & ~lane) | (data & lane);
   endfunction

   function automatic logic mapped(input logic [11:0] idx);
      case (idx)
         IDX_P1_ENABLES, IDX_P1_SLOPE, IDX_P1_KNEE, IDX_P1_GATE,
         IDX_P2_ENABLES, IDX_P2_RATES, IDX_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [11:0] word_idx(input logic [AXI_ADDR_W-1:0] addr);
      word_idx = addr[AXI_ADDR_W-1:2];
   endfunction

   assign aw_take = s_axi_awvalid && awready_r;
   assign w_take = s_axi_wvalid && wready_r;
   // Write happens once both halves are held and no response is pending
   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit = mapped(wr_idx_r) && (wr_idx_r != IDX_STATUS);
   assign ar_take = s_axi_arvalid && arready_r;
   assign rd_idx = word_idx(s_axi_araddr);

   // Address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         aw_held_r <= 1'b0;
         wr_idx_r <= 12'h000;
      end else if (ce) begin
         if (aw_take) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            wr_idx_r <= word_idx(s_axi_awaddr);
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         w_held_r <= 1'b0;
         wr_data_r <= 16'h0000;
         wr_strb_r <= 2'h0;
      end else if (ce) begin
         if (w_take) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wr_data_r <= s_axi_wdata[15:0];
            wr_strb_r <= s_axi_wstrb[1:0];
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
         end
      end
   end

   // Unmapped or read-only targets answer SLVERR; only a status write changes state, reloading the sticky record
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Codes are stored as written, reserved or not
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p1_enables_r <= RST_ENABLES_P1;
         p1_slope_r <= RST_SLOPE;
         p1_knee_r <= RST_KNEE;
         p1_gate_r <= RST_GATE;
      end else if (ce && do_write) begin
         case (wr_idx_r)
            IDX_P1_ENABLES: begin
               p1_enables_r <= merge(p1_enables_r, wr_data_r, wr_strb_r, MASK_ENABLES_P1);
            end
            IDX_P1_SLOPE: begin
               p1_slope_r <= merge(p1_slope_r, wr_data_r, wr_strb_r, MASK_SLOPE);
            end
            IDX_P1_KNEE: begin
               p1_knee_r <= merge(p1_knee_r, wr_data_r, wr_strb_r, MASK_KNEE);
            end
            IDX_P1_GATE: begin
               p1_gate_r <= merge(p1_gate_r, wr_data_r, wr_strb_r, MASK_GATE);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2_enables_r <= RST_ENABLES_P2;
         p2_rates_r <= RST_RATES;
      end else if (ce && do_write) begin
         case (wr_idx_r)
            IDX_P2_ENABLES: begin
               p2_enables_r <= merge(p2_enables_r, wr_data_r, wr_strb_r, MASK_ENABLES_P2);
            end
            IDX_P2_RATES: begin
               p2_rates_r <= merge(p2_rates_r, wr_data_r, wr_strb_r, MASK_RATES);
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky record of reserved codes seen; any status write attempt reloads it with the current flags
   always_comb begin
      reserved_seen_nxt = reserved_seen_r | reserved_flags;
      if (do_write && (wr_idx_r == IDX_STATUS)) begin
         reserved_seen_nxt = reserved_flags;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reserved_seen_r <= 6'h00;
      end else if (ce) begin
         reserved_seen_r <= reserved_seen_nxt;
      end
   end

   always_comb begin
      rd_hit = mapped(rd_idx);
      case (rd_idx)
         IDX_P1_ENABLES: rd_word = p1_enables_r;
         IDX_P1_SLOPE: rd_word = p1_slope_r;
         IDX_P1_KNEE: rd_word = p1_knee_r;
         IDX_P1_GATE: rd_word = p1_gate_r;
         IDX_P2_ENABLES: rd_word = p2_enables_r;
         IDX_P2_RATES: rd_word = p2_rates_r;
         IDX_STATUS: rd_word = {2'h0, reserved_seen_r, 2'h0, reserved_flags};
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_word};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   drc_param_check u_check (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .slope(p1_slope_r[LSB_SLOPE +: 3]),
      .knee_in(p1_knee_r[LSB_KNEE_IN +: 6]),
      .knee_out(p1_knee_r[LSB_KNEE_OUT +: 5]),
      .gate_ena(p1_enables_r[BIT_GATE_ENA]),
      .gate_out_ena(p1_enables_r[BIT_KNEE_OUT_ENA]),
      .attack(p2_rates_r[LSB_ATTACK +: 4]),
      .decay(p2_rates_r[LSB_DECAY +: 4]),
      .min_gain(p2_rates_r[LSB_MIN_GAIN +: 3]),
      .gate_in_active(path1_gate_in_active),
      .gate_out_active(path1_gate_out_active),
      .min_gain_db(path2_min_gain_db),
      .reserved_flags(reserved_flags)
   );

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   assign path1_lower_slope = p1_slope_r[LSB_SLOPE +: 3];
   assign path1_knee_in_level = p1_knee_r[LSB_KNEE_IN +: 6];
   assign path1_knee_out_level = p1_knee_r[LSB_KNEE_OUT +: 5];
   assign path1_gate_knee_in_level = p1_gate_r[LSB_GATE_IN +: 5];
   assign path1_gate_knee_out_level = p1_gate_r[LSB_GATE_OUT +: 5];
   assign path1_gate_enable = p1_enables_r[BIT_GATE_ENA];
   assign path1_gate_knee_out_enable = p1_enables_r[BIT_KNEE_OUT_ENA];
   assign path2_gate_enable = p2_enables_r[BIT_GATE_ENA];
   assign path2_gate_knee_out_enable = p2_enables_r[BIT_KNEE_OUT_ENA];
   assign path2_quick_release_enable = p2_enables_r[BIT_QR_ENA];
   assign path2_anti_clip_enable = p2_enables_r[BIT_ANTICLIP_ENA];
   assign path2_attack_rate = p2_rates_r[LSB_ATTACK +: 4];
   assign path2_decay_rate = p2_rates_r[LSB_DECAY +: 4];
   assign path2_min_gain = p2_rates_r[LSB_MIN_GAIN +: 3];
endmodule

// >>> verilog/drc_regs_pkg.sv
// Purpose: Shared map and field layout of the dynamic range controller registers
// Assumes: 32-bit AXI4-Lite, word index times four gives the byte address
// Notes: Printed offsets are word indices, not byte addresses
package drc_regs_pkg;
   localparam int AXI_ADDR_W = 14;
   localparam logic [11:0] IDX_P1_ENABLES = 12'h440;
   localparam logic [11:0] IDX_P1_SLOPE = 12'h442;
   localparam logic [11:0] IDX_P1_KNEE = 12'h443;
   localparam logic [11:0] IDX_P1_GATE = 12'h444;
   localparam logic [11:0] IDX_P2_ENABLES = 12'h540;
   localparam logic [11:0] IDX_P2_RATES = 12'h541;
   localparam logic [11:0] IDX_STATUS = 12'h5ff;
   // Writable bits per register; the rest read as zero
   localparam logic [15:0] MASK_ENABLES_P1 = 16'h0120;
   localparam logic [15:0] MASK_SLOPE = 16'h0007;
   localparam logic [15:0] MASK_KNEE = 16'h07ff;
   localparam logic [15:0] MASK_GATE = 16'h03ff;
   localparam logic [15:0] MASK_ENABLES_P2 = 16'h0138;
   localparam logic [15:0] MASK_RATES = 16'h1ffc;
   localparam logic [15:0] RST_ENABLES_P1 = 16'h0000;
   localparam logic [15:0] RST_SLOPE = 16'h0000;
   localparam logic [15:0] RST_KNEE = 16'h0000;
   localparam logic [15:0] RST_GATE = 16'h0000;
   localparam logic [15:0] RST_ENABLES_P2 = 16'h0018;
   localparam logic [15:0] RST_RATES = 16'h0844;
   localparam int BIT_GATE_ENA = 8;
   localparam int BIT_KNEE_OUT_ENA = 5;
   localparam int BIT_QR_ENA = 4;
   localparam int BIT_ANTICLIP_ENA = 3;
   localparam int LSB_KNEE_IN = 5;
   localparam int LSB_KNEE_OUT = 0;
   localparam int LSB_GATE_IN = 5;
   localparam int LSB_GATE_OUT = 0;
   localparam int LSB_SLOPE = 0;
   localparam int LSB_ATTACK = 9;
   localparam int LSB_DECAY = 5;
   localparam int LSB_MIN_GAIN = 2;
   // Highest defined codes, plus the lowest attack code; anything outside is reserved
   localparam logic [2:0] SLOPE_MAX = 3'h4;
   localparam logic [5:0] KNEE_IN_MAX = 6'h3c;
   localparam logic [4:0] KNEE_OUT_MAX = 5'h1e;
   localparam logic [3:0] ATTACK_MIN = 4'h1;
   localparam logic [3:0] ATTACK_MAX = 4'hb;
   localparam logic [3:0] DECAY_MAX = 4'h8;
   localparam logic [2:0] MIN_GAIN_MAX = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
